// >>> core/dip_pkg.sv
/*
  dip_pkg: shared types and constants of the dual-issue pairing control.
  Assumes the decoder in front presents pre-classified instruction slots.
*/
package dip_pkg;

  // instruction classes as delivered by the decode stage
  typedef enum logic [4:0] {
    OPC_NOP   = 5'h00,
    OPC_MOV   = 5'h01,
    OPC_NOT   = 5'h02,
    OPC_SLD   = 5'h03,
    OPC_SST   = 5'h04,
    OPC_SAT   = 5'h05,
    OPC_MULH  = 5'h06,
    OPC_LOGIC = 5'h07,
    OPC_TST   = 5'h08,
    OPC_ARITH = 5'h09,
    OPC_CMP   = 5'h0a,
    OPC_SHIFT = 5'h0b,
    OPC_EXT   = 5'h0c,
    OPC_BR    = 5'h0d,
    OPC_BCC   = 5'h0e,
    OPC_LD    = 5'h0f,
    OPC_OTHER = 5'h10
  } dip_opc_t;

  // encoding format of the instruction
  typedef enum logic [1:0] {
    FMT_I     = 2'h0,
    FMT_II    = 2'h1,
    FMT_IV    = 2'h2,
    FMT_OTHER = 2'h3
  } dip_fmt_t;

  // issue decision
  typedef enum logic [1:0] {
    MD_SINGLE = 2'h0,
    MD_PAIR   = 2'h1,
    MD_FUSE   = 2'h2
  } dip_mode_t;

  localparam int         REG_W        = 5;
  localparam int         ADDR_W       = 32;
  localparam logic [4:0] ZERO_REG     = 5'h00;
  localparam logic [4:0] ELEM_PTR_REG = 5'h1e;
  localparam logic [2:0] EP_WB_CYC    = 3'h3;
  localparam logic [1:0] LB_DEPTH     = 2'h2;
  localparam logic [1:0] LB_RST       = 2'h0;
  localparam logic [2:0] EP_RST       = 3'h0;

  // reason bits in the decision word
  localparam int WHY_MIS  = 0;
  localparam int WHY_EP   = 1;
  localparam int WHY_FLAG = 2;
  localparam int WHY_LB   = 3;

  typedef struct packed {
    logic              vld;
    dip_opc_t          opc;
    dip_fmt_t          fmt;
    logic              wr;
    logic [REG_W-1:0]  dst;
    logic [ADDR_W-1:0] addr;
  } dip_slot_t;

  typedef struct packed {
    logic fuse_op;
    logic br_ok;
    logic bcc_ok;
    logic sld_ok;
    logic sets_flags;
    logic is_br;
    logic is_bcc;
    logic is_sld;
    logic is_load;
    logic is_mov;
  } dip_elig_t;

  typedef struct packed {
    logic      vld;
    dip_mode_t mode;
    logic [3:0] why;
  } dip_dec_t;

endpackage

// >>> core/dip_classify.sv
/*
  dip_classify: per-slot eligibility decode for pairing and fusion.
  Assumes a slot with vld low is ignored; all flags then read zero.
*/
`timescale 1ns/1ps
module dip_classify (
  input  dip_pkg::dip_slot_t slot,
  output dip_pkg::dip_elig_t elig
);

  // pure table lookup on class and format
  always_comb begin
    dip_pkg::dip_opc_t o;
    dip_pkg::dip_fmt_t f;
    o = slot.opc;
    f = slot.fmt;
    elig = '0;
    if (slot.vld) begin
      // mov fused with a following op on the same destination
      elig.is_mov  = (o == dip_pkg::OPC_MOV) && (f == dip_pkg::FMT_I);
      elig.fuse_op = (f == dip_pkg::FMT_I || f == dip_pkg::FMT_II) &&
                     (o inside {dip_pkg::OPC_SAT, dip_pkg::OPC_MULH, dip_pkg::OPC_LOGIC,
                                dip_pkg::OPC_ARITH, dip_pkg::OPC_SHIFT});
      // first slot allowed ahead of a branch, a conditional branch or a short load
      unique case (f)
        dip_pkg::FMT_I: begin
          elig.br_ok  = o inside {dip_pkg::OPC_NOP, dip_pkg::OPC_MOV, dip_pkg::OPC_NOT,
                                  dip_pkg::OPC_SLD, dip_pkg::OPC_SAT, dip_pkg::OPC_MULH,
                                  dip_pkg::OPC_LOGIC, dip_pkg::OPC_TST, dip_pkg::OPC_ARITH,
                                  dip_pkg::OPC_CMP, dip_pkg::OPC_SHIFT};
          elig.bcc_ok = o inside {dip_pkg::OPC_NOP, dip_pkg::OPC_MOV, dip_pkg::OPC_SLD,
                                  dip_pkg::OPC_MULH, dip_pkg::OPC_EXT};
          elig.sld_ok = elig.br_ok && (o != dip_pkg::OPC_SLD);
        end
        dip_pkg::FMT_II: begin
          elig.br_ok  = o inside {dip_pkg::OPC_MOV, dip_pkg::OPC_SAT, dip_pkg::OPC_ARITH,
                                  dip_pkg::OPC_CMP, dip_pkg::OPC_SHIFT, dip_pkg::OPC_MULH};
          elig.bcc_ok = o inside {dip_pkg::OPC_MOV, dip_pkg::OPC_MULH};
          elig.sld_ok = elig.br_ok;
        end
        dip_pkg::FMT_IV: begin
          elig.br_ok  = o inside {dip_pkg::OPC_SLD, dip_pkg::OPC_SST};
          elig.bcc_ok = elig.br_ok;
          elig.sld_ok = 1'b0;
        end
        dip_pkg::FMT_OTHER: begin
          elig.br_ok  = 1'b0;
          elig.bcc_ok = 1'b0;
          elig.sld_ok = 1'b0;
        end
      endcase
      // unknown classes are assumed to touch the flags, the safe side
      elig.sets_flags = o inside {dip_pkg::OPC_NOT, dip_pkg::OPC_SAT, dip_pkg::OPC_LOGIC,
                                  dip_pkg::OPC_TST, dip_pkg::OPC_ARITH, dip_pkg::OPC_CMP,
                                  dip_pkg::OPC_SHIFT, dip_pkg::OPC_OTHER};
      elig.is_br   = (o == dip_pkg::OPC_BR);
      elig.is_bcc  = (o == dip_pkg::OPC_BCC);
      elig.is_sld  = (o == dip_pkg::OPC_SLD);
      elig.is_load = (o == dip_pkg::OPC_SLD) || (o == dip_pkg::OPC_LD);
    end
  end

endmodule

// >>> core/dip_pair_ctl.sv
/*
  dip_pair_ctl: decides single, paired or fused issue of two
  consecutive decoded instructions and tracks the pairing hazards.
  Assumes IN_A is the older instruction, IN_B the one after it, and
  that the load path pulses LB_WB_DONE once per load written back.
  Upstream must advance by two slots after a pair or fusion and by one
  otherwise; the block trusts that and keeps no program counter.
  REDIRECT marks the next IN_A as the first instruction after a branch.
  CE low stalls every tracker, so hazard windows count CE cycles only.
*/
`timescale 1ns/1ps
module dip_pair_ctl #(
  parameter logic [2:0] EP_CYC = dip_pkg::EP_WB_CYC,
  parameter logic [1:0] LB_NUM = dip_pkg::LB_DEPTH
) (
  input  wire logic              CLK,
  input  wire logic              RSTN,
  input  wire logic              CE,
  input  dip_pkg::dip_slot_t     IN_A,
  input  dip_pkg::dip_slot_t     IN_B,
  input  wire logic              REDIRECT,
  input  wire logic              LB_WB_DONE,
  output dip_pkg::dip_dec_t      DEC_OUT,
  output logic                   EP_PEND,
  output logic                   LB_FULL
);

  dip_pkg::dip_elig_t ea;
  dip_pkg::dip_elig_t eb;

  dip_classify u_cls_a (
    .slot (IN_A),
    .elig (ea)
  );

  dip_classify u_cls_b (
    .slot (IN_B),
    .elig (eb)
  );

  // state
  dip_pkg::dip_dec_t dec_ff;
  dip_pkg::dip_dec_t nxt_dec;
  logic              flg_prev_ff;
  logic              nxt_flg_prev;
  logic              after_br_ff;
  logic              nxt_after_br;
  logic [2:0]        ep_cnt_ff;
  logic [2:0]        nxt_ep_cnt;
  logic [1:0]        lb_cnt_ff;
  logic [1:0]        nxt_lb_cnt;
  logic              ep_pend_ff;
  logic              nxt_ep_pend;
  logic              lb_full_ff;
  logic              nxt_lb_full;

  // combinational decision terms
  logic ce_go;
  logic mis_blk;
  logic fuse_c;
  logic flag_haz;
  logic ep_haz;
  logic lb_haz;
  logic pair_c;
  logic a_wr_ep;
  logic b_wr_ep;
  logic two;
  logic [1:0] lds;
  logic [2:0] lb_sum;

  // writes of the pointer base make later short loads unsafe
  function automatic logic wr_ep(input dip_pkg::dip_slot_t s);
    return s.vld && s.wr && (s.dst == dip_pkg::ELEM_PTR_REG);
  endfunction

  assign ce_go   = CE && IN_A.vld;
  assign a_wr_ep = wr_ep(IN_A);
  assign b_wr_ep = wr_ep(IN_B);

  // hazard terms for fuse and pair; only mis_blk is shared by both
  always_comb begin
    mis_blk  = after_br_ff && (IN_A.addr[1:0] != 2'h0);
    // the instruction before the branch and the one issued before it
    flag_haz = ea.sets_flags || flg_prev_ff;
    ep_haz   = (ep_cnt_ff != dip_pkg::EP_RST) || a_wr_ep;
    lb_haz   = (lb_cnt_ff >= LB_NUM);
    // older slot must be the mov; op-then-mov never fuses
    fuse_c   = ea.is_mov && eb.fuse_op && IN_A.wr && IN_B.wr &&
               (IN_A.dst == IN_B.dst) && (IN_A.dst != dip_pkg::ZERO_REG) && !mis_blk;
    // second slot limited to br, bcc, sld
    pair_c   = !fuse_c && !mis_blk &&
               ((eb.is_br && ea.br_ok) ||
                (eb.is_bcc && ea.bcc_ok && !flag_haz) ||
                (eb.is_sld && ea.sld_ok && !ep_haz && !lb_haz &&
                 !(IN_A.wr && IN_B.wr && IN_A.dst == IN_B.dst)));
  end

  // next decision word and hazard trackers
  always_comb begin
    nxt_dec      = dec_ff;
    nxt_flg_prev = flg_prev_ff;
    nxt_after_br = after_br_ff || REDIRECT;
    nxt_ep_cnt   = ep_cnt_ff;
    nxt_lb_cnt   = lb_cnt_ff;
    two          = fuse_c || pair_c;
    lds          = 2'h0;
    if (ep_cnt_ff != dip_pkg::EP_RST) begin
      nxt_ep_cnt = ep_cnt_ff - 3'h1;
    end
    if (ce_go) begin
      nxt_dec.vld           = 1'b1;
      nxt_dec.mode          = fuse_c ? dip_pkg::MD_FUSE :
                              (pair_c ? dip_pkg::MD_PAIR : dip_pkg::MD_SINGLE);
      nxt_dec.why           = '0;
      nxt_dec.why[dip_pkg::WHY_MIS]  = mis_blk;
      nxt_dec.why[dip_pkg::WHY_EP]   = eb.is_sld && ep_haz;
      nxt_dec.why[dip_pkg::WHY_FLAG] = eb.is_bcc && flag_haz;
      nxt_dec.why[dip_pkg::WHY_LB]   = eb.is_sld && lb_haz;
      // last consumed instruction decides the flag history
      nxt_flg_prev = two ? (eb.sets_flags || (fuse_c && ea.sets_flags)) : ea.sets_flags;
      // a redirect arriving now marks the next issue, not this one
      nxt_after_br = REDIRECT;
      if (a_wr_ep || (two && b_wr_ep)) begin
        nxt_ep_cnt = EP_CYC;
      end
      lds = {1'b0, ea.is_load} + {1'b0, two && eb.is_load};
    end else begin
      nxt_dec.vld = 1'b0;
    end
    // load buffer occupancy, saturating at the buffer count
    // spare top bit: a full count plus new loads must not wrap to zero
    lb_sum = {1'b0, lb_cnt_ff} + {1'b0, lds} - {2'h0, LB_WB_DONE};
    if ({1'b0, lb_cnt_ff} + {1'b0, lds} > {2'h0, LB_WB_DONE}) begin
      nxt_lb_cnt = (lb_sum > {1'b0, LB_NUM}) ? LB_NUM : lb_sum[1:0];
    end else begin
      nxt_lb_cnt = dip_pkg::LB_RST;
    end
    nxt_ep_pend = (nxt_ep_cnt != dip_pkg::EP_RST);
    nxt_lb_full = (nxt_lb_cnt >= LB_NUM);
  end

  // registers; CE low freezes everything
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      dec_ff      <= '0;
      flg_prev_ff <= 1'b0;
      after_br_ff <= 1'b0;
      ep_cnt_ff   <= dip_pkg::EP_RST;
      lb_cnt_ff   <= dip_pkg::LB_RST;
      ep_pend_ff  <= 1'b0;
      lb_full_ff  <= 1'b0;
    end else if (CE) begin
      dec_ff      <= nxt_dec;
      flg_prev_ff <= nxt_flg_prev;
      after_br_ff <= nxt_after_br;
      ep_cnt_ff   <= nxt_ep_cnt;
      lb_cnt_ff   <= nxt_lb_cnt;
      ep_pend_ff  <= nxt_ep_pend;
      lb_full_ff  <= nxt_lb_full;
    end
  end

  assign DEC_OUT = dec_ff;
  assign EP_PEND = ep_pend_ff;
  assign LB_FULL = lb_full_ff;

  // checks on the decision against its causes
  AST_FUSE_TAKEN: assert property (@(posedge CLK) disable iff (!RSTN)
    ce_go && ea.is_mov && eb.fuse_op && IN_A.wr && IN_B.wr &&
    IN_A.dst == IN_B.dst && IN_A.dst != dip_pkg::ZERO_REG && !mis_blk
    |=> DEC_OUT.vld && DEC_OUT.mode == dip_pkg::MD_FUSE)
    else $error("mov plus op not fused");

  AST_FUSE_MOV_FIRST: assert property (@(posedge CLK) disable iff (!RSTN)
    $rose(DEC_OUT.vld && DEC_OUT.mode == dip_pkg::MD_FUSE)
    |-> $past(IN_A.opc) == dip_pkg::OPC_MOV && $past(IN_A.dst) != dip_pkg::ZERO_REG)
    else $error("fusion without leading mov");

  AST_BR_PAIR: assert property (@(posedge CLK) disable iff (!RSTN)
    ce_go && eb.is_br && ea.br_ok && !fuse_c && !mis_blk
    |=> DEC_OUT.mode == dip_pkg::MD_PAIR)
    else $error("eligible branch pair not issued");

  AST_BCC_NEUTRAL: assert property (@(posedge CLK) disable iff (!RSTN)
    ce_go && eb.is_bcc && ea.sets_flags |=> DEC_OUT.mode != dip_pkg::MD_PAIR)
    else $error("bcc paired after flag writer");

  AST_SLD_PAIR: assert property (@(posedge CLK) disable iff (!RSTN)
    ce_go && eb.is_sld && !ea.sld_ok |=> DEC_OUT.mode == dip_pkg::MD_SINGLE)
    else $error("short load paired with ineligible first");

  AST_SECOND_KIND: assert property (@(posedge CLK) disable iff (!RSTN)
    ce_go && !(eb.is_br || eb.is_bcc || eb.is_sld) |=> DEC_OUT.mode != dip_pkg::MD_PAIR)
    else $error("pair with illegal second");

  AST_MISALIGN: assert property (@(posedge CLK) disable iff (!RSTN)
    ce_go && after_br_ff && IN_A.addr[1:0] != 2'h0
    |=> DEC_OUT.mode == dip_pkg::MD_SINGLE && DEC_OUT.why[dip_pkg::WHY_MIS])
    else $error("pair after misaligned target");

  AST_EP_HOLD: assert property (@(posedge CLK) disable iff (!RSTN)
    CE && ce_go && a_wr_ep |=> EP_PEND && ep_cnt_ff == EP_CYC)
    else $error("pointer write not tracked");

  AST_FLAG_PREV: assert property (@(posedge CLK) disable iff (!RSTN)
    ce_go && flg_prev_ff && eb.is_bcc |=> DEC_OUT.mode != dip_pkg::MD_PAIR)
    else $error("bcc paired with older flag writer pending");

  AST_LB_FULL: assert property (@(posedge CLK) disable iff (!RSTN)
    ce_go && LB_FULL && eb.is_sld |=> DEC_OUT.mode != dip_pkg::MD_PAIR)
    else $error("short load paired with full buffers");

  AST_SAME_DST: assert property (@(posedge CLK) disable iff (!RSTN)
    ce_go && eb.is_sld && IN_A.wr && IN_B.wr && IN_A.dst == IN_B.dst
    |=> DEC_OUT.mode != dip_pkg::MD_PAIR)
    else $error("pair with colliding destinations");

  // decision word and freeze behaviour
  AST_VLD_FOLLOW: assert property (@(posedge CLK) disable iff (!RSTN)
    CE
    |=> DEC_OUT.vld == $past(IN_A.vld))
    else $error("decision valid does not follow first slot");

  AST_HOLD_FROZEN: assert property (@(posedge CLK) disable iff (!RSTN)
    !CE
    |=> $stable(DEC_OUT) && $stable(EP_PEND) && $stable(LB_FULL))
    else $error("state moved while clock enable low");

  AST_WHY_QUIET: assert property (@(posedge CLK) disable iff (!RSTN)
    ce_go && !eb.is_sld && !eb.is_bcc
    |=> DEC_OUT.why[3:1] == 3'h0)
    else $error("hazard reason set for an unaffected second slot");

  // fusion limits
  AST_FUSE_NO_R0: assert property (@(posedge CLK) disable iff (!RSTN)
    ce_go && IN_A.dst == dip_pkg::ZERO_REG
    |=> DEC_OUT.mode != dip_pkg::MD_FUSE)
    else $error("fusion onto the zero register");

  AST_FUSE_DST_DIFF: assert property (@(posedge CLK) disable iff (!RSTN)
    ce_go && IN_A.dst != IN_B.dst
    |=> DEC_OUT.mode != dip_pkg::MD_FUSE)
    else $error("fusion of different destinations");

  AST_FUSE_ONLY_MOV: assert property (@(posedge CLK) disable iff (!RSTN)
    ce_go && IN_A.opc != dip_pkg::OPC_MOV
    |=> DEC_OUT.mode != dip_pkg::MD_FUSE)
    else $error("fusion with a non-mov first slot");

  // bcc eligibility and hazard trackers
  AST_BCC_ELIG: assert property (@(posedge CLK) disable iff (!RSTN)
    ce_go && eb.is_bcc && !ea.bcc_ok
    |=> DEC_OUT.mode != dip_pkg::MD_PAIR)
    else $error("bcc paired with ineligible first");

  AST_BCC_FLAG_WHY: assert property (@(posedge CLK) disable iff (!RSTN)
    ce_go && eb.is_bcc && (ea.sets_flags || flg_prev_ff)
    |=> DEC_OUT.why[dip_pkg::WHY_FLAG] && DEC_OUT.mode == dip_pkg::MD_SINGLE)
    else $error("flag hazard on bcc not reported");

  AST_FLAG_TRACK: assert property (@(posedge CLK) disable iff (!RSTN)
    ce_go && !fuse_c && !pair_c
    |=> flg_prev_ff == $past(ea.sets_flags))
    else $error("flag history lost on single issue");

  AST_REDIRECT_ARM: assert property (@(posedge CLK) disable iff (!RSTN)
    CE && REDIRECT
    |=> after_br_ff)
    else $error("redirect not remembered");

  AST_EP_COUNTDOWN: assert property (@(posedge CLK) disable iff (!RSTN)
    CE && ep_cnt_ff != dip_pkg::EP_RST && !(ce_go && (a_wr_ep || (two && b_wr_ep)))
    |=> ep_cnt_ff == $past(ep_cnt_ff) - 3'h1)
    else $error("pointer write countdown stalled");

  AST_SLD_EP_WHY: assert property (@(posedge CLK) disable iff (!RSTN)
    ce_go && eb.is_sld && (ep_cnt_ff != dip_pkg::EP_RST || a_wr_ep)
    |=> DEC_OUT.why[dip_pkg::WHY_EP] && DEC_OUT.mode == dip_pkg::MD_SINGLE)
    else $error("short load paired over pending pointer write");

  AST_LB_BOUND: assert property (@(posedge CLK) disable iff (!RSTN)
    lb_cnt_ff <= LB_NUM)
    else $error("load buffer count beyond buffer number");

  AST_LB_INC: assert property (@(posedge CLK) disable iff (!RSTN)
    ce_go && ea.is_load && !(two && eb.is_load) && !LB_WB_DONE && lb_cnt_ff < LB_NUM
    |=> lb_cnt_ff == $past(lb_cnt_ff) + 2'h1)
    else $error("issued load not counted");

  AST_LB_DEC: assert property (@(posedge CLK) disable iff (!RSTN)
    CE && !ce_go && LB_WB_DONE && lb_cnt_ff != dip_pkg::LB_RST
    |=> lb_cnt_ff == $past(lb_cnt_ff) - 2'h1)
    else $error("written-back load not released");

endmodule

// >>> testbench/dual_issue_pairing_control_tb.sv
/*
  dual_issue_pairing_control_tb: directed scenarios for dip_pair_ctl.
  Assumes dip_pkg and the core files are compiled before this file.
*/
`timescale 1ns/1ps
module dual_issue_pairing_control_tb;
  logic               CLK;
  logic               RSTN;
  logic               CE;
  logic               REDIRECT;
  logic               LB_WB_DONE;
  dip_pkg::dip_slot_t IN_A;
  dip_pkg::dip_slot_t IN_B;
  dip_pkg::dip_dec_t  DEC_OUT;
  logic               EP_PEND;
  logic               LB_FULL;
  int                 n_fail;
  int                 checked;
  dip_pkg::dip_slot_t nop;
  dip_pkg::dip_slot_t br;
  dip_pkg::dip_slot_t bcc;
  dip_pkg::dip_slot_t sld;

  dip_pair_ctl u_dut (.CLK(CLK), .RSTN(RSTN), .CE(CE), .IN_A(IN_A), .IN_B(IN_B),
    .REDIRECT(REDIRECT), .LB_WB_DONE(LB_WB_DONE), .DEC_OUT(DEC_OUT),
    .EP_PEND(EP_PEND), .LB_FULL(LB_FULL));

  // 25 MHz core clock
  initial begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end

  // slot builder; format follows the class so the classifier sees legal words
  function automatic dip_pkg::dip_slot_t mk(dip_pkg::dip_opc_t o, logic w, logic [4:0] d);
    mk = '0;
    mk.vld = 1'b1;
    mk.opc = o;
    mk.wr = w;
    mk.dst = d;
    mk.addr = 32'h0000_1000;
    mk.fmt = dip_pkg::FMT_I;
    if (o inside {dip_pkg::OPC_SLD, dip_pkg::OPC_SST})
      mk.fmt = dip_pkg::FMT_IV;
    if (o inside {dip_pkg::OPC_BR, dip_pkg::OPC_BCC, dip_pkg::OPC_OTHER})
      mk.fmt = dip_pkg::FMT_OTHER;
  endfunction

  // compare helpers, four-state exact
  task automatic cm(string s, dip_pkg::dip_mode_t e, dip_pkg::dip_mode_t g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s exp %0h got %0h", s, e, g);
    end
  endtask

  task automatic cb(string s, logic [3:0] e, logic [3:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s exp %0h got %0h", s, e, g);
    end
  endtask

  task automatic conclude();
    $display("compares %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // short reset clears hazard history between isolated cases
  task automatic rst();
    @(negedge CLK);
    RSTN = 1'b0;
    @(negedge CLK);
    RSTN = 1'b1;
  endtask

  // present one pair, judge the decision one edge later, then go idle
  task automatic go(dip_pkg::dip_slot_t a, dip_pkg::dip_slot_t b, dip_pkg::dip_mode_t e,
                    logic [3:0] w);
    @(negedge CLK);
    IN_A = a;
    IN_B = b;
    @(negedge CLK);
    cb("vld", 4'h1, {3'h0, DEC_OUT.vld});
    cm("mode", e, DEC_OUT.mode);
    cb("why", w, DEC_OUT.why);
    IN_A = '0;
    IN_B = '0;
  endtask

  task automatic t_fuse();
    dip_pkg::dip_opc_t  ops[5];
    dip_pkg::dip_slot_t mv;
    dip_pkg::dip_slot_t ad;
    ops = '{dip_pkg::OPC_SAT, dip_pkg::OPC_MULH, dip_pkg::OPC_LOGIC, dip_pkg::OPC_ARITH,
            dip_pkg::OPC_SHIFT};
    mv = mk(dip_pkg::OPC_MOV, 1'b1, 5'h05);
    ad = mk(dip_pkg::OPC_ARITH, 1'b1, 5'h05);
    foreach (ops[i]) go(mv, mk(ops[i], 1'b1, 5'h05), dip_pkg::MD_FUSE, 4'h0);
    go(ad, mv, dip_pkg::MD_SINGLE, 4'h0);
    go(mv, ad, dip_pkg::MD_FUSE, 4'h0);
    // frozen clock enable must keep the last decision standing
    CE = 1'b0;
    repeat (2) @(negedge CLK);
    cm("hold", dip_pkg::MD_FUSE, DEC_OUT.mode);
    CE = 1'b1;
    mv.dst = 5'h00;
    ad.dst = 5'h00;
    go(mv, ad, dip_pkg::MD_SINGLE, 4'h0);
  endtask

  task automatic t_br();
    dip_pkg::dip_opc_t ops[12];
    ops = '{dip_pkg::OPC_NOP, dip_pkg::OPC_MOV, dip_pkg::OPC_NOT, dip_pkg::OPC_SLD,
            dip_pkg::OPC_SAT, dip_pkg::OPC_MULH, dip_pkg::OPC_LOGIC, dip_pkg::OPC_TST,
            dip_pkg::OPC_ARITH, dip_pkg::OPC_CMP, dip_pkg::OPC_SHIFT, dip_pkg::OPC_SST};
    foreach (ops[i]) go(mk(ops[i], 1'b0, 5'h01), br, dip_pkg::MD_PAIR, 4'h0);
    go(mk(dip_pkg::OPC_OTHER, 1'b0, 5'h01), br, dip_pkg::MD_SINGLE, 4'h0);
  endtask

  task automatic t_bcc();
    dip_pkg::dip_opc_t ops[6];
    ops = '{dip_pkg::OPC_NOP, dip_pkg::OPC_MOV, dip_pkg::OPC_SLD, dip_pkg::OPC_MULH,
            dip_pkg::OPC_EXT, dip_pkg::OPC_SST};
    foreach (ops[i]) begin
      rst();
      go(mk(ops[i], 1'b0, 5'h01), bcc, dip_pkg::MD_PAIR, 4'h0);
    end
    rst();
    go(mk(dip_pkg::OPC_ARITH, 1'b0, 5'h01), bcc, dip_pkg::MD_SINGLE, 4'h4);
    go(mk(dip_pkg::OPC_CMP, 1'b0, 5'h01), '0, dip_pkg::MD_SINGLE, 4'h0);
    go(nop, bcc, dip_pkg::MD_SINGLE, 4'h4);
  endtask

  task automatic t_sld();
    dip_pkg::dip_opc_t ops[10];
    ops = '{dip_pkg::OPC_NOP, dip_pkg::OPC_MOV, dip_pkg::OPC_NOT, dip_pkg::OPC_SAT,
            dip_pkg::OPC_MULH, dip_pkg::OPC_LOGIC, dip_pkg::OPC_TST, dip_pkg::OPC_ARITH,
            dip_pkg::OPC_CMP, dip_pkg::OPC_SHIFT};
    foreach (ops[i]) begin
      rst();
      go(mk(ops[i], 1'b1, 5'h01), sld, dip_pkg::MD_PAIR, 4'h0);
    end
    rst();
    go(mk(dip_pkg::OPC_SST, 1'b0, 5'h01), sld, dip_pkg::MD_SINGLE, 4'h0);
    go(nop, mk(dip_pkg::OPC_ARITH, 1'b1, 5'h02), dip_pkg::MD_SINGLE, 4'h0);
    go(nop, mk(dip_pkg::OPC_LD, 1'b1, 5'h02), dip_pkg::MD_SINGLE, 4'h0);
    go(mk(dip_pkg::OPC_MOV, 1'b1, 5'h02), sld, dip_pkg::MD_SINGLE, 4'h0);
  endtask

  // redirect pulse, then the first instruction after it at address ad
  task automatic t_mis(logic [31:0] ad, dip_pkg::dip_slot_t b, dip_pkg::dip_mode_t e,
                       logic [3:0] w);
    dip_pkg::dip_slot_t a;
    a = (b.opc == dip_pkg::OPC_BR) ? nop : mk(dip_pkg::OPC_MOV, 1'b1, 5'h05);
    a.addr = ad;
    @(negedge CLK);
    REDIRECT = 1'b1;
    @(negedge CLK);
    REDIRECT = 1'b0;
    go(a, b, e, w);
  endtask

  task automatic t_ep();
    int n;
    rst();
    go(mk(dip_pkg::OPC_MOV, 1'b1, dip_pkg::ELEM_PTR_REG), sld, dip_pkg::MD_SINGLE,
       4'h2);
    cb("ep_pend", 4'h1, {3'h0, EP_PEND});
    go(nop, sld, dip_pkg::MD_SINGLE, 4'h2);
    n = 0;
    while (EP_PEND !== 1'b0 && n < 8) begin
      @(negedge CLK);
      n++;
    end
    if (n == 8) begin
      cb("ep_wait", 4'h0, {3'h0, EP_PEND});
      conclude();
    end
    go(nop, sld, dip_pkg::MD_PAIR, 4'h0);
  endtask

  task automatic t_lb();
    rst();
    go(mk(dip_pkg::OPC_LD, 1'b1, 5'h03), '0, dip_pkg::MD_SINGLE, 4'h0);
    go(mk(dip_pkg::OPC_LD, 1'b1, 5'h04), '0, dip_pkg::MD_SINGLE, 4'h0);
    go(nop, sld, dip_pkg::MD_SINGLE, 4'h8);
    cb("lb_full", 4'h1, {3'h0, LB_FULL});
    LB_WB_DONE = 1'b1;
    @(negedge CLK);
    LB_WB_DONE = 1'b0;
    @(negedge CLK);
    cb("lb_full", 4'h0, {3'h0, LB_FULL});
    go(nop, sld, dip_pkg::MD_PAIR, 4'h0);
  endtask

  // main sequence: reset for 6 cycles, then every scenario in turn
  initial begin
    n_fail = 0;
    checked = 0;
    RSTN = 1'b0;
    CE = 1'b1;
    REDIRECT = 1'b0;
    LB_WB_DONE = 1'b0;
    IN_A = '0;
    IN_B = '0;
    nop = mk(dip_pkg::OPC_NOP, 1'b0, 5'h01);
    br = mk(dip_pkg::OPC_BR, 1'b0, 5'h00);
    bcc = mk(dip_pkg::OPC_BCC, 1'b0, 5'h00);
    sld = mk(dip_pkg::OPC_SLD, 1'b1, 5'h02);
    repeat (6) @(negedge CLK);
    RSTN = 1'b1;
    t_fuse();
    t_br();
    t_bcc();
    t_sld();
    t_mis(32'h0000_1006, br, dip_pkg::MD_SINGLE, 4'h1);
    t_mis(32'h0000_1004, br, dip_pkg::MD_PAIR, 4'h0);
    t_mis(32'h0000_1006, mk(dip_pkg::OPC_ARITH, 1'b1, 5'h05), dip_pkg::MD_SINGLE, 4'h1);
    t_ep();
    t_lb();
    conclude();
  end
endmodule
